/* File: inc/tfcf_map.svh */
`ifndef TFCF_MAP_SVH
`define TFCF_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define TFCF_ADDR_W 4
`define TFCF_OFS_DATA_HIGH 4'h0
`define TFCF_OFS_DATA_LOW 4'h4
`define TFCF_OFS_CTRL 4'h8
`define TFCF_OFS_STATUS 4'hC

// ------------------------------------------------------------
// Fields, reset values and timing
// ------------------------------------------------------------
`define TFCF_CTRL_ARM_BIT 0
`define TFCF_CTRL_EVONLY_BIT 1
`define TFCF_CTRL_END_BIT 2
`define TFCF_CTRL_RESET 3'h0
`define TFCF_DEPTH 8
`define TFCF_BLANK_CYCLES 2
`endif

/* File: inc/tfcf_pkg.sv */
package tfcf_pkg;
    typedef logic [15:0] tfcf_word_t;
    typedef enum logic [2:0] {
        TFCF_CF_NONE,
        TFCF_CF_BRANCH,
        TFCF_CF_UNCOND,
        TFCF_CF_INDIRECT,
        TFCF_CF_RETURN
    } tfcf_cf_e;
    typedef enum {TFCF_IDLE, TFCF_BLANK, TFCF_RUN} tfcf_state_e;
endpackage : tfcf_pkg

/* File: inc/tfcf_push_if.sv */
`timescale 1ns/1ns
interface tfcf_push_if;
    logic push;
    logic shift;
    logic [15:0] push_data;
    logic [15:0] head;
    logic [3:0] count;
    modport src (output push, output shift, output push_data,
        input head, input count);
    modport fifo (input push, input shift, input push_data,
        output head, output count);
endinterface : tfcf_push_if

/* File: src/tfcf_fifo.sv */
`timescale 1ns/1ns
`include "tfcf_map.svh"
module tfcf_fifo #(
    parameter int DEPTH = `TFCF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    tfcf_push_if.fifo p
);
    logic [15:0] mem [DEPTH];
    logic [3:0] count_reg;

    // ------------------------------------------------------------
    // Shift register: push at tail, low read drops head
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 16'h0000;
            end
        end else if (p.push) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem[i] <= mem[i + 1];
            end
            mem[DEPTH - 1] <= p.push_data;
        end else if (p.shift) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem[i] <= mem[i + 1];
            end
            mem[DEPTH - 1] <= 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_reg <= 4'h0;
        end else if (p.push && !p.shift && count_reg != 4'(DEPTH)) begin
            count_reg <= count_reg + 4'h1;
        end else if (p.shift && !p.push && count_reg != 4'h0) begin
            count_reg <= count_reg - 4'h1;
        end
    end

    // Oldest slot is a dummy stage; the port shows the next one
    assign p.head = mem[1];
    assign p.count = count_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    depth_a: assert property (@(posedge sys_clk) disable iff (reset)
        count_reg <= 4'(DEPTH)) else $error("count above depth");
    count_step_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        p.push && !p.shift && count_reg != 4'(DEPTH)
        |=> count_reg == $past(count_reg) + 4'h1) else $error("count step");
endmodule : tfcf_fifo

/* File: src/tfcf_classify.sv */
`timescale 1ns/1ns
module tfcf_classify (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_tag,
    input wire logic exec_valid,
    input wire logic exec_flushed,
    input wire logic [2:0] exec_kind,
    input wire logic branch_taken,
    input wire logic [15:0] exec_src,
    input wire logic [15:0] exec_dest,
    output logic cf_event,
    output logic [15:0] cf_addr,
    output logic tag_fire,
    output logic [15:0] last_fetch
);
    logic tag_pend_reg;

    // ------------------------------------------------------------
    // Tag at fetch, act on execution only
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tag_pend_reg <= 1'b0;
            last_fetch <= 16'h0000;
        end else begin
            if (fetch_valid) begin
                last_fetch <= fetch_addr;
            end
            if (fetch_valid) begin
                tag_pend_reg <= fetch_tag;
            end else if (exec_valid) begin
                tag_pend_reg <= 1'b0;
            end
        end
    end

    assign tag_fire = exec_valid && !exec_flushed && tag_pend_reg;

    always_comb begin
        cf_event = 1'b0;
        cf_addr = exec_dest;
        if (exec_valid && !exec_flushed) begin
            unique case (tfcf_pkg::tfcf_cf_e'(exec_kind))
                tfcf_pkg::TFCF_CF_NONE: cf_event = 1'b0;
                tfcf_pkg::TFCF_CF_UNCOND: cf_event = 1'b0;
                tfcf_pkg::TFCF_CF_BRANCH: begin
                    cf_event = branch_taken;
                    cf_addr = exec_src;
                end
                tfcf_pkg::TFCF_CF_INDIRECT: cf_event = 1'b1;
                tfcf_pkg::TFCF_CF_RETURN: cf_event = 1'b1;
                default: cf_event = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flush_mute_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        exec_flushed |-> !cf_event && !tag_fire)
        else $error("flushed opcode acted");
    uncond_mute_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        exec_kind == 3'h2 |-> !cf_event) else $error("unconditional stored");
    taken_src_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        exec_valid && !exec_flushed && exec_kind == 3'h1 && branch_taken
        |-> cf_event && cf_addr == exec_src) else $error("branch source lost");
endmodule : tfcf_classify

/* File: src/tfcf_trace.sv */
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "tfcf_map.svh"
module tfcf_trace (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TFCF_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_tag,
    input wire logic exec_valid,
    input wire logic exec_flushed,
    input wire logic [2:0] exec_kind,
    input wire logic branch_taken,
    input wire logic [15:0] exec_src,
    input wire logic [15:0] exec_dest,
    input wire logic [7:0] event_data
);
    tfcf_push_if pif ();
    logic cf_event;
    logic [15:0] cf_addr;
    logic tag_fire;
    logic [15:0] last_fetch;
    logic [2:0] ctrl_reg;
    tfcf_pkg::tfcf_state_e state_reg;
    logic [1:0] blank_reg;
    logic low_rd;
    logic req;

    tfcf_classify u_cls (
        .sys_clk(sys_clk),
        .reset(reset),
        .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr),
        .fetch_tag(fetch_tag),
        .exec_valid(exec_valid),
        .exec_flushed(exec_flushed),
        .exec_kind(exec_kind),
        .branch_taken(branch_taken),
        .exec_src(exec_src),
        .exec_dest(exec_dest),
        .cf_event(cf_event),
        .cf_addr(cf_addr),
        .tag_fire(tag_fire),
        .last_fetch(last_fetch)
    );

    tfcf_fifo #(.DEPTH(`TFCF_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .p(pif)
    );

    // ------------------------------------------------------------
    // Wishbone slave, one wait cycle
    // ------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign low_rd = req && !wb_we_i && wb_adr_i == `TFCF_OFS_DATA_LOW;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `TFCF_CTRL_RESET;
        end else if (req && wb_we_i && wb_adr_i == `TFCF_OFS_CTRL
            && wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[2:0];
        end else if (state_reg == tfcf_pkg::TFCF_RUN && tag_fire
            && ctrl_reg[`TFCF_CTRL_END_BIT]) begin
            ctrl_reg[`TFCF_CTRL_ARM_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `TFCF_OFS_DATA_HIGH: wb_dat_o <= ctrl_reg[`TFCF_CTRL_EVONLY_BIT]
                    ? 32'h0000_0000 : {24'h00_0000, pif.head[15:8]};
                `TFCF_OFS_DATA_LOW: wb_dat_o <= {24'h00_0000, pif.head[7:0]};
                `TFCF_OFS_CTRL: wb_dat_o <= {29'h0000_0000, ctrl_reg};
                `TFCF_OFS_STATUS: wb_dat_o <= {28'h000_0000, pif.count};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trace run control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= tfcf_pkg::TFCF_IDLE;
            blank_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                tfcf_pkg::TFCF_IDLE: begin
                    if (ctrl_reg[`TFCF_CTRL_ARM_BIT] && (tag_fire
                        || ctrl_reg[`TFCF_CTRL_END_BIT])) begin
                        state_reg <= ctrl_reg[`TFCF_CTRL_END_BIT]
                            ? tfcf_pkg::TFCF_RUN : tfcf_pkg::TFCF_BLANK;
                        blank_reg <= 2'(`TFCF_BLANK_CYCLES);
                    end
                end
                tfcf_pkg::TFCF_BLANK: begin
                    blank_reg <= blank_reg - 2'h1;
                    if (blank_reg == 2'h1) begin
                        state_reg <= tfcf_pkg::TFCF_RUN;
                    end
                end
                tfcf_pkg::TFCF_RUN: begin
                    if (!ctrl_reg[`TFCF_CTRL_ARM_BIT]) begin
                        state_reg <= tfcf_pkg::TFCF_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // FIFO push selection
    // ------------------------------------------------------------
    always_comb begin
        pif.push = 1'b0;
        pif.push_data = cf_addr;
        pif.shift = low_rd;
        if (!ctrl_reg[`TFCF_CTRL_ARM_BIT]) begin
            pif.push = low_rd;
            pif.push_data = last_fetch;
        end else if (ctrl_reg[`TFCF_CTRL_EVONLY_BIT]) begin
            pif.push = state_reg == tfcf_pkg::TFCF_RUN && tag_fire;
            pif.push_data = {8'h00, event_data};
        end else if (state_reg == tfcf_pkg::TFCF_RUN) begin
            pif.push = cf_event;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    blank_gap_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_reg == tfcf_pkg::TFCF_BLANK && ctrl_reg[0] && !ctrl_reg[1]
        |-> !pif.push) else $error("push during blank");
    blank_len_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_reg == tfcf_pkg::TFCF_BLANK && blank_reg == 2'h2
        |=> state_reg == tfcf_pkg::TFCF_BLANK
        ##1 state_reg == tfcf_pkg::TFCF_RUN) else $error("blank length");
    idle_quiet_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        ctrl_reg[`TFCF_CTRL_ARM_BIT] && !ctrl_reg[`TFCF_CTRL_EVONLY_BIT]
        && state_reg != tfcf_pkg::TFCF_RUN |-> !pif.push)
        else $error("push before run");
    run_store_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        ctrl_reg[`TFCF_CTRL_ARM_BIT] && !ctrl_reg[`TFCF_CTRL_EVONLY_BIT]
        && state_reg == tfcf_pkg::TFCF_RUN
        |-> pif.push == cf_event && pif.push_data == cf_addr)
        else $error("change of flow not stored");
    stop_on_tag_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        state_reg == tfcf_pkg::TFCF_RUN && tag_fire
        && ctrl_reg[`TFCF_CTRL_END_BIT] && !(req && wb_we_i)
        |=> !ctrl_reg[`TFCF_CTRL_ARM_BIT]) else $error("arm kept");
    profile_push_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        low_rd && !ctrl_reg[`TFCF_CTRL_ARM_BIT]
        |-> pif.push && pif.push_data == last_fetch)
        else $error("profile push missing");
    high_unused_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        req && !wb_we_i && wb_adr_i == `TFCF_OFS_DATA_HIGH
        && ctrl_reg[`TFCF_CTRL_EVONLY_BIT]
        |=> wb_dat_o == 32'h0000_0000) else $error("high port in use");
    low_shift_a: assert property (
        @(posedge sys_clk) disable iff (reset)
        low_rd |-> pif.shift) else $error("low read without shift");
    ack_once_a: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : tfcf_trace

/* File: verif/tfcf_cpu_model.sv */
`timescale 1ns/1ns
module tfcf_cpu_model (
    input wire logic sys_clk,
    output logic fetch_valid,
    output logic [15:0] fetch_addr,
    output logic fetch_tag,
    output logic exec_valid,
    output logic exec_flushed,
    output logic [2:0] exec_kind,
    output logic branch_taken,
    output logic [15:0] exec_src,
    output logic [15:0] exec_dest,
    output logic [7:0] event_data
);
    initial begin
        {fetch_valid, fetch_tag, exec_valid, exec_flushed} = 4'h0;
        {exec_kind, branch_taken} = 4'h0;
        {fetch_addr, exec_src, exec_dest} = 48'h0000_0000_0000;
        event_data = 8'h00;
    end
    // Fetch one opcode, then execute or flush it
    task automatic op(input logic [2:0] kind, input logic tkn,
        input logic [15:0] a, input logic tag, input logic fl);
        @(posedge sys_clk);
        fetch_valid <= 1'b1;
        fetch_addr <= a;
        fetch_tag <= tag;
        @(posedge sys_clk);
        fetch_valid <= 1'b0;
        fetch_addr <= ~a;
        fetch_tag <= 1'b0;
        exec_valid <= 1'b1;
        exec_flushed <= fl;
        exec_kind <= kind;
        branch_taken <= tkn;
        exec_src <= a;
        exec_dest <= a + 16'h0100;
        event_data <= a[7:0];
        @(posedge sys_clk);
        exec_valid <= 1'b0;
        exec_flushed <= 1'b0;
        exec_src <= ~a;
        exec_dest <= ~a;
        event_data <= ~a[7:0];
    endtask : op
endmodule : tfcf_cpu_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
`include "tfcf_map.svh"
module tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic fv, ft, ev, ef, bt;
    logic [15:0] fa, es, ed;
    logic [2:0] ek;
    logic [7:0] edat;
    logic [31:0] q;
    logic [15:0] exp_q[$];
    int errors = 0;
    int cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    tfcf_trace dut_u (.sys_clk(sys_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_valid(fv),
        .fetch_addr(fa), .fetch_tag(ft), .exec_valid(ev),
        .exec_flushed(ef), .exec_kind(ek), .branch_taken(bt),
        .exec_src(es), .exec_dest(ed), .event_data(edat));
    tfcf_cpu_model cpu_u (.sys_clk(sys_clk), .fetch_valid(fv),
        .fetch_addr(fa), .fetch_tag(ft), .exec_valid(ev),
        .exec_flushed(ef), .exec_kind(ek), .branch_taken(bt),
        .exec_src(es), .exec_dest(ed), .event_data(edat));
    // ------------------------------------------------------------
    // Bus, check, report and reset tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            complete_run();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rd
    task automatic dump(input logic evonly);
        logic [31:0] hi;
        rd(`TFCF_OFS_STATUS, 32'(exp_q.size()));
        repeat (`TFCF_DEPTH - exp_q.size() - 1) begin
            wb(1'b0, `TFCF_OFS_DATA_LOW, 32'h0000_0000);
        end
        foreach (exp_q[i]) begin
            hi = evonly ? 32'h0000_0000 : {24'h00_0000, exp_q[i][15:8]};
            rd(`TFCF_OFS_DATA_HIGH, hi);
            rd(`TFCF_OFS_DATA_LOW, {24'h00_0000, exp_q[i][7:0]});
        end
    endtask : dump
    task automatic rst;
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : rst
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst();
        rd(`TFCF_OFS_STATUS, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        // Profiling with the last fetch held while the CPU idles
        cpu_u.op(3'h0, 1'b0, 16'h1234, 1'b0, 1'b0);
        repeat (8) wb(1'b0, `TFCF_OFS_DATA_LOW, 32'h0000_0000);
        rd(`TFCF_OFS_DATA_HIGH, 32'h0000_0012);
        rd(`TFCF_OFS_DATA_LOW, 32'h0000_0034);
        // Armed end-trace run
        rst();
        wb(1'b1, `TFCF_OFS_CTRL, 32'h0000_0005);
        cpu_u.op(3'h0, 1'b0, 16'h1000, 1'b0, 1'b0);
        cpu_u.op(3'h1, 1'b1, 16'h1100, 1'b0, 1'b0);
        cpu_u.op(3'h1, 1'b0, 16'h1200, 1'b0, 1'b0);
        cpu_u.op(3'h2, 1'b1, 16'h1300, 1'b0, 1'b0);
        cpu_u.op(3'h3, 1'b0, 16'h1400, 1'b0, 1'b0);
        cpu_u.op(3'h4, 1'b0, 16'h1600, 1'b0, 1'b0);
        cpu_u.op(3'h1, 1'b1, 16'h1800, 1'b1, 1'b1);
        cpu_u.op(3'h1, 1'b1, 16'h1900, 1'b1, 1'b0);
        cpu_u.op(3'h1, 1'b1, 16'h1A00, 1'b0, 1'b0);
        exp_q = '{16'h1100, 16'h1500, 16'h1700, 16'h1900};
        dump(1'b0);
        // Begin-trace run drops the trigger itself
        rst();
        wb(1'b1, `TFCF_OFS_CTRL, 32'h0000_0001);
        cpu_u.op(3'h1, 1'b1, 16'h3100, 1'b1, 1'b0);
        cpu_u.op(3'h4, 1'b0, 16'h3200, 1'b0, 1'b0);
        exp_q = '{16'h3300};
        dump(1'b0);
        // Event-only mode leaves the high port unused
        rst();
        wb(1'b1, `TFCF_OFS_CTRL, 32'h0000_0003);
        cpu_u.op(3'h3, 1'b0, 16'h2055, 1'b1, 1'b0);
        cpu_u.op(3'h0, 1'b0, 16'h2077, 1'b1, 1'b0);
        exp_q = '{16'h0077};
        dump(1'b1);
        complete_run();
    end
endmodule : tb
